/* dv/dsf_host.sv */
// host model: writer and reader logic beside dsf_fifo
// assumes flags and busy on mclk; the bench sets word limits
`timescale 1ns/1ps
`default_nettype none
module dsf_host (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // word limits from bench
    input wire logic [15:0] wr_lim,
    input wire logic [15:0] rd_lim,
    input wire logic ignore_flags,
    // fifo side
    input wire dsf_pkg::dsf_flags_s flags,
    input wire logic busy,
    output logic wr_en,
    output logic [17:0] wr_data,
    output logic rd_en,
    output logic rd_got_ff
);
    logic [15:0] wr_tot_ff;
    logic [15:0] rd_tot_ff;
    logic busy_ff;
    logic quiet;
    ////////////////////////////////////////
    // one extra edge after recovery
    assign quiet = !busy && !busy_ff;
    assign wr_en = (wr_tot_ff < wr_lim) && (flags.full_indicator_n || ignore_flags) && quiet;
    assign rd_en = (rd_tot_ff < rd_lim) && (flags.empty_indicator_n || ignore_flags) && quiet;
    assign wr_data = {2'b00, wr_tot_ff} ^ 18'h2AAAA;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_tot_ff <= 16'h0000;
            rd_tot_ff <= 16'h0000;
            busy_ff <= 1'b0;
            rd_got_ff <= 1'b0;
        end else begin
            wr_tot_ff <= wr_tot_ff + {15'h0000, wr_en && flags.full_indicator_n};
            rd_tot_ff <= rd_tot_ff + {15'h0000, rd_en && flags.empty_indicator_n};
            busy_ff <= busy;
            rd_got_ff <= rd_en && flags.empty_indicator_n;
        end
    end
endmodule // dsf_host
`default_nettype wire

/* dv/tb.sv */
// bench for dsf_fifo with a small depth and the host model
// assumes one 125 MHz clock and the design's own assertions
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int DEPTH = 32;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic oe_n = 1'b0;
    logic sync_flag_select = 1'b0;
    logic retransmit = 1'b0;
    logic ignore_flags = 1'b0;
    logic [4:0] empty_offset = 5'h03;
    logic [4:0] full_offset = 5'h04;
    logic [15:0] wr_lim = 16'h0000;
    logic [15:0] rd_lim = 16'h0000;
    logic wr_en, rd_en, rd_got_ff, rd_data_oe, retransmit_busy, wr_expand_out, rd_expand_out;
    logic [17:0] wr_data, rd_data;
    dsf_pkg::dsf_flags_s flags;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int rd_idx = 0;
    int cnt = 0;
    int cnt_d = 0;
    int wx = 0;
    int rx = 0;
    logic mon_on = 1'b0;
    ////////////////////////////////////////
    dsf_fifo #(.DEPTH(DEPTH), .BUF_DEPTH(8), .RTR_CYC(8)) dut (
        .mclk(mclk), .rst_n(rst_n), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .oe_n(oe_n),
        .rd_data(rd_data), .rd_data_oe(rd_data_oe), .sync_flag_select(sync_flag_select),
        .empty_offset(empty_offset), .full_offset(full_offset), .retransmit(retransmit),
        .flags(flags), .retransmit_busy(retransmit_busy), .wr_expand_out(wr_expand_out),
        .rd_expand_out(rd_expand_out));
    dsf_host host (.mclk(mclk), .rst_n(rst_n), .wr_lim(wr_lim), .rd_lim(rd_lim), .ignore_flags(ignore_flags),
        .flags(flags),
        .busy(retransmit_busy), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_got_ff(rd_got_ff));
    initial begin
        forever #4 mclk = ~mclk;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cb(input logic got, input logic exp, input string what);
        chk({17'h00000, got}, {17'h00000, exp}, what);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wait_cnt(input int want);
        int k;
        for (k = 0; k < 400 && cnt != want; k++) @(posedge mclk);
        chk(cnt[17:0], want[17:0], "fill level");
        tick(3);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // read words, flag levels against model count, pulses, timeout
    always @(posedge mclk) begin
        if (rd_got_ff) begin
            chk(rd_data, rd_idx[17:0] ^ 18'h2AAAA, "read word");
            rd_idx++;
        end
        if (mon_on) begin
            cb(flags.full_indicator_n, cnt != DEPTH, "full");
            cb(flags.almost_full_indicator_n, (sync_flag_select ? cnt : cnt_d) < DEPTH - int'(full_offset),
                "almost full");
            cb(flags.almost_empty_indicator_n, (sync_flag_select ? cnt : cnt_d) > int'(empty_offset),
                "almost empty");
        end
        wx += int'(wr_expand_out);
        rx += int'(rd_expand_out);
        cnt_d = cnt;
        cnt = cnt + int'(wr_en && flags.full_indicator_n && !retransmit_busy)
            - int'(rd_en && flags.empty_indicator_n && !retransmit_busy);
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("wrong value at %0t: timeout", $time);
            complete_run();
        end
    end
    ////////////////////////////////////////
    initial begin
        tick(11);
        chk({14'h0000, flags}, 18'h0000A, "reset flags");
        chk(rd_data, 18'h00000, "reset data");
        cb(rd_data_oe, 1'b1, "drive on");
        oe_n <= 1'b1;
        tick(1);
        rst_n <= 1'b1;
        tick(1);
        cb(rd_data_oe, 1'b0, "drive off");
        oe_n <= 1'b0;
        $display("test reset done");
        wr_lim <= 16'h0001;
        tick(2);
        cb(flags.empty_indicator_n, 1'b0, "empty before staging");
        tick(1);
        cb(flags.empty_indicator_n, 1'b1, "empty after staging");
        rd_lim <= 16'h0001;
        tick(4);
        cb(flags.empty_indicator_n, 1'b0, "empty after read");
        $display("test first word done");
        wr_lim <= 16'h0005;
        rd_lim <= 16'h0003;
        tick(20);
        retransmit <= 1'b1;
        tick(1);
        retransmit <= 1'b0;
        rd_idx = 0;
        repeat (8) begin
            tick(1);
            cb(retransmit_busy, 1'b1, "recovery");
        end
        tick(1);
        cb(retransmit_busy, 1'b0, "recovery end");
        rd_lim <= 16'h0008;
        tick(30);
        chk(rd_idx[17:0], 18'h00005, "words after rewind");
        cb(flags.empty_indicator_n, 1'b0, "empty after rewind");
        $display("test retransmit done");
        rst_n <= 1'b0;
        wr_lim <= 16'h0000;
        rd_lim <= 16'h0000;
        tick(3);
        chk({14'h0000, flags}, 18'h0000A, "second reset flags");
        chk(rd_data, 18'h00000, "second reset data");
        rst_n <= 1'b1;
        rd_idx = 0;
        cnt = 0;
        cnt_d = 0;
        wx = 0;
        rx = 0;
        tick(2);
        mon_on = 1'b1;
        wr_lim <= 16'h0020;
        wait_cnt(DEPTH);
        chk(wx[17:0], 18'h00001, "write expansion");
        ignore_flags <= 1'b1;
        wr_lim <= 16'h0021;
        tick(4);
        chk(cnt[17:0], 18'h00020, "write while full");
        cb(flags.full_indicator_n, 1'b0, "full held");
        ignore_flags <= 1'b0;
        wr_lim <= 16'h0020;
        rd_lim <= 16'h0020;
        wait_cnt(0);
        chk(rx[17:0], 18'h00001, "read expansion");
        ignore_flags <= 1'b1;
        rd_lim <= 16'h0021;
        tick(4);
        chk(rd_data, 18'h0001F ^ 18'h2AAAA, "read while empty");
        cb(flags.empty_indicator_n, 1'b0, "empty held");
        ignore_flags <= 1'b0;
        rd_lim <= 16'h0020;
        mon_on = 1'b0;
        $display("test sync flags done");
        sync_flag_select <= 1'b1;
        empty_offset <= 5'h05;
        full_offset <= 5'h02;
        tick(3);
        mon_on = 1'b1;
        wr_lim <= 16'h003F;
        wait_cnt(31);
        rd_lim <= 16'h003F;
        wait_cnt(0);
        mon_on = 1'b0;
        chk(rd_idx[17:0], 18'h0003F, "words read");
        $display("test async flags done");
        complete_run();
    end
endmodule // tb
`default_nettype wire

/* rtl/dsf_buf.sv */
// small staging fifo, flip-flop storage, valid/ready both sides
// assumes one clock; flush empties it in one cycle
`timescale 1ns/1ps
`default_nettype none
module dsf_buf #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int IW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2) begin : g_bad
        $error("dsf_buf depth must be at least 2");
    end

    logic [WIDTH-1:0] store [DEPTH];
    logic [IW-1:0] head_ff;
    logic [IW-1:0] tail_ff;
    logic [CW-1:0] cnt_ff;
    logic push;
    logic pop;

    assign in_ready = cnt_ff != CW'(DEPTH);
    assign out_valid = cnt_ff != '0;
    assign out_data = store[head_ff];
    assign count = cnt_ff;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (push) begin
            store[tail_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tail_ff <= '0;
        end else if (flush) begin
            tail_ff <= '0;
        end else if (push) begin
            tail_ff <= (tail_ff == IW'(DEPTH - 1)) ? '0 : tail_ff + IW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            head_ff <= '0;
        end else if (flush) begin
            head_ff <= '0;
        end else if (pop) begin
            head_ff <= (head_ff == IW'(DEPTH - 1)) ? '0 : head_ff + IW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else if (flush) begin
            cnt_ff <= '0;
        end else if (push && !pop) begin
            cnt_ff <= cnt_ff + CW'(1);
        end else if (pop && !push) begin
            cnt_ff <= cnt_ff - CW'(1);
        end
    end

endmodule // dsf_buf
`default_nettype wire

/* rtl/dsf_fifo.sv */
// deep synchronous fifo: main store, staging fifo, flags,
// retransmit and depth-expansion pulses
// assumes writer and reader are logic on mclk
`timescale 1ns/1ps
`default_nettype none
module dsf_fifo #(
    parameter int WIDTH = dsf_pkg::FIFO_WIDTH,
    parameter int DEPTH = dsf_pkg::FIFO_DEPTH,
    parameter int BUF_DEPTH = dsf_pkg::STAGE_DEPTH,
    parameter int RTR_CYC = dsf_pkg::RTR_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // write side
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    // read side
    input wire logic rd_en,
    input wire logic oe_n,
    output logic [WIDTH-1:0] rd_data,
    output logic rd_data_oe,
    // configuration
    input wire logic sync_flag_select,
    input wire logic [$clog2(DEPTH)-1:0] empty_offset,
    input wire logic [$clog2(DEPTH)-1:0] full_offset,
    input wire logic retransmit,
    // status
    output var dsf_pkg::dsf_flags_s flags,
    output logic retransmit_busy,
    // depth expansion
    output logic wr_expand_out,
    output logic rd_expand_out
);
    localparam int MEM_DEPTH = DEPTH - BUF_DEPTH;
    localparam int AW = $clog2(MEM_DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int BW = $clog2(BUF_DEPTH + 1);
    localparam int RW = $clog2(RTR_CYC + 1);
    localparam logic [AW-1:0] LAST_LOC = AW'(MEM_DEPTH - 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    if (MEM_DEPTH < 2 || RTR_CYC < 1 || RTR_CYC > 8) begin : g_bad
        $error("dsf_fifo parameters out of range");
    end

    ////////////////////////////////////////////////////////////////
    // storage and counters
    logic [WIDTH-1:0] mem [MEM_DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [CW-1:0] mem_cnt_ff;
    logic [CW-1:0] total_cnt_ff;
    logic [CW-1:0] nxt_total_cnt;
    logic [RW-1:0] rt_cnt_ff;
    dsf_pkg::dsf_rt_e rt_state_ff;
    logic full_n_ff;
    logic aempty_n_ff;
    logic afull_n_ff;
    logic aempty_now_n;
    logic afull_now_n;
    logic [WIDTH-1:0] rd_data_ff;
    logic wx_ff;
    logic rx_ff;
    logic busy;
    logic rt_go;
    logic wr_fire;
    logic rd_fire;
    logic mv;
    logic b_in_ready;
    logic b_out_valid;
    logic [WIDTH-1:0] b_out_data;
    logic [BW-1:0] b_count;

    assign busy = rt_state_ff == dsf_pkg::RT_RECOV;
    assign rt_go = retransmit & ~busy;
    assign wr_fire = wr_en & full_n_ff & ~busy;
    assign rd_fire = rd_en & b_out_valid & ~busy;
    assign mv = (mem_cnt_ff != '0) & b_in_ready & ~busy;

    ////////////////////////////////////////////////////////////////
    // staging fifo between store and reader
    dsf_buf #(
        .WIDTH(WIDTH),
        .DEPTH(BUF_DEPTH)
    ) u_stage (
        .clk(mclk),
        .rst_n(rst_n),
        .flush(rt_go),
        .in_valid(mv),
        .in_ready(b_in_ready),
        .in_data(mem[rd_ptr_ff]),
        .out_valid(b_out_valid),
        .out_ready(rd_en & ~busy),
        .out_data(b_out_data),
        .count(b_count)
    );

    ////////////////////////////////////////////////////////////////
    // main store write and pointers
    always_ff @(posedge mclk) begin
        if (wr_fire) begin
            mem[wr_ptr_ff] <= wr_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
        end else if (wr_fire) begin
            wr_ptr_ff <= (wr_ptr_ff == LAST_LOC) ? '0 : wr_ptr_ff + AW'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr_ff <= '0;
        end else if (rt_go) begin
            rd_ptr_ff <= '0;
        end else if (mv) begin
            rd_ptr_ff <= (rd_ptr_ff == LAST_LOC) ? '0 : rd_ptr_ff + AW'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_cnt_ff <= '0;
        end else if (rt_go) begin
            mem_cnt_ff <= CW'(wr_ptr_ff) + CW'(wr_fire);
        end else if (wr_fire && !mv) begin
            mem_cnt_ff <= mem_cnt_ff + CW'(1);
        end else if (mv && !wr_fire) begin
            mem_cnt_ff <= mem_cnt_ff - CW'(1);
        end
    end

    always_comb begin
        nxt_total_cnt = total_cnt_ff;
        if (rt_go) begin
            nxt_total_cnt = CW'(wr_ptr_ff) + CW'(wr_fire);
        end else if (wr_fire && !rd_fire) begin
            nxt_total_cnt = total_cnt_ff + CW'(1);
        end else if (rd_fire && !wr_fire) begin
            nxt_total_cnt = total_cnt_ff - CW'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            total_cnt_ff <= '0;
        end else begin
            total_cnt_ff <= nxt_total_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // retransmit recovery
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rt_state_ff <= dsf_pkg::RT_IDLE;
            rt_cnt_ff <= '0;
        end else begin
            unique case (rt_state_ff)
                dsf_pkg::RT_IDLE: begin
                    if (rt_go) begin
                        rt_state_ff <= dsf_pkg::RT_RECOV;
                        rt_cnt_ff <= RW'(RTR_CYC - 1);
                    end
                end
                dsf_pkg::RT_RECOV: begin
                    if (rt_cnt_ff == '0) begin
                        rt_state_ff <= dsf_pkg::RT_IDLE;
                    end else begin
                        rt_cnt_ff <= rt_cnt_ff - RW'(1);
                    end
                end
            endcase
        end
    end

    assign retransmit_busy = busy;

    ////////////////////////////////////////////////////////////////
    // flags
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            full_n_ff <= dsf_pkg::RST_FULL_N;
        end else begin
            full_n_ff <= nxt_total_cnt != FULL_CNT;
        end
    end

    assign aempty_now_n = total_cnt_ff > CW'(empty_offset);
    assign afull_now_n = total_cnt_ff < (FULL_CNT - CW'(full_offset));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aempty_n_ff <= dsf_pkg::RST_AEMPTY_N;
            afull_n_ff <= dsf_pkg::RST_AFULL_N;
        end else begin
            aempty_n_ff <= aempty_now_n;
            afull_n_ff <= afull_now_n;
        end
    end

    always_comb begin
        flags.full_indicator_n = full_n_ff;
        flags.empty_indicator_n = b_out_valid;
        flags.almost_empty_indicator_n = sync_flag_select ? aempty_now_n : aempty_n_ff;
        flags.almost_full_indicator_n = sync_flag_select ? afull_now_n : afull_n_ff;
    end

    ////////////////////////////////////////////////////////////////
    // read data and drive
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= '0;
        end else if (rd_fire) begin
            rd_data_ff <= b_out_data;
        end
    end

    assign rd_data = rd_data_ff;
    assign rd_data_oe = ~oe_n;

    ////////////////////////////////////////////////////////////////
    // depth expansion pulses
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wx_ff <= dsf_pkg::RST_BIT;
            rx_ff <= dsf_pkg::RST_BIT;
        end else begin
            wx_ff <= wr_fire && (wr_ptr_ff == LAST_LOC);
            rx_ff <= mv && (rd_ptr_ff == LAST_LOC);
        end
    end

    assign wr_expand_out = wx_ff;
    assign rd_expand_out = rx_ff;

    ////////////////////////////////////////////////////////////////
    // checks
    property p_full_blocks;
        @(posedge mclk) disable iff (!rst_n)
        (!flags.full_indicator_n && wr_en && !rd_en && !retransmit)
        |=> total_cnt_ff == $past(total_cnt_ff);
    endproperty
    a_full_blocks: assert property (p_full_blocks)
        else $error("write accepted while full");

    property p_full_flag;
        @(posedge mclk) disable iff (!rst_n)
        (total_cnt_ff == FULL_CNT) |-> !flags.full_indicator_n;
    endproperty
    a_full_flag: assert property (p_full_flag)
        else $error("full count without full indicator");

    sequence s_wr_into_empty;
        wr_fire && total_cnt_ff == '0 && !busy && !retransmit;
    endsequence

    sequence s_quiet_step;
        !retransmit && !rd_en;
    endsequence

    property p_first_latency;
        @(posedge mclk) disable iff (!rst_n)
        s_wr_into_empty ##1 s_quiet_step |=> flags.empty_indicator_n;
    endproperty
    a_first_latency: assert property (p_first_latency)
        else $error("first word not staged within two cycles");

    property p_empty_flag;
        @(posedge mclk) disable iff (!rst_n)
        (total_cnt_ff == '0) |-> !flags.empty_indicator_n;
    endproperty
    a_empty_flag: assert property (p_empty_flag)
        else $error("empty indicator high with no words");

    property p_first_word;
        @(posedge mclk) disable iff (!rst_n)
        rd_fire |=> rd_data == $past(b_out_data);
    endproperty
    a_first_word: assert property (p_first_word)
        else $error("read data not the head word");

    property p_data_hold;
        @(posedge mclk) disable iff (!rst_n)
        !rd_fire |=> $stable(rd_data);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("read data moved without a read");

    property p_sync_aempty;
        @(posedge mclk) disable iff (!rst_n)
        (!sync_flag_select && total_cnt_ff <= CW'(empty_offset)) ##1 !sync_flag_select
        |-> !flags.almost_empty_indicator_n;
    endproperty
    a_sync_aempty: assert property (p_sync_aempty)
        else $error("almost empty not low one cycle after count");

    property p_async_afull;
        @(posedge mclk) disable iff (!rst_n)
        (sync_flag_select && total_cnt_ff >= FULL_CNT - CW'(full_offset))
        |-> !flags.almost_full_indicator_n;
    endproperty
    a_async_afull: assert property (p_async_afull)
        else $error("almost full not low at threshold");

    property p_wr_expand;
        @(posedge mclk) disable iff (!rst_n)
        (wr_fire && wr_ptr_ff == LAST_LOC) |=> wr_expand_out ##1 !wr_expand_out;
    endproperty
    a_wr_expand: assert property (p_wr_expand)
        else $error("write expansion pulse wrong");

    property p_rd_expand;
        @(posedge mclk) disable iff (!rst_n)
        (mv && rd_ptr_ff == LAST_LOC) |=> rd_expand_out ##1 !rd_expand_out;
    endproperty
    a_rd_expand: assert property (p_rd_expand)
        else $error("read expansion pulse wrong");

    property p_rt_recover;
        @(posedge mclk) disable iff (!rst_n)
        rt_go |=> retransmit_busy [*8] ##1 !retransmit_busy;
    endproperty
    a_rt_recover: assert property (p_rt_recover)
        else $error("retransmit recovery length wrong");

    property p_sync_afull;
        @(posedge mclk) disable iff (!rst_n)
        (!sync_flag_select && total_cnt_ff >= FULL_CNT - CW'(full_offset)) ##1 !sync_flag_select
        |-> !flags.almost_full_indicator_n;
    endproperty
    a_sync_afull: assert property (p_sync_afull)
        else $error("almost full not low one cycle after count");

    property p_async_aempty;
        @(posedge mclk) disable iff (!rst_n)
        (sync_flag_select && total_cnt_ff <= CW'(empty_offset))
        |-> !flags.almost_empty_indicator_n;
    endproperty
    a_async_aempty: assert property (p_async_aempty)
        else $error("almost empty not low at threshold");

    property p_full_clears;
        @(posedge mclk) disable iff (!rst_n)
        (!flags.full_indicator_n && rd_fire && !wr_fire && !rt_go) |=> flags.full_indicator_n;
    endproperty
    a_full_clears: assert property (p_full_clears)
        else $error("full indicator held after a read");

    property p_busy_freeze;
        @(posedge mclk) disable iff (!rst_n)
        busy |=> b_count == $past(b_count) && total_cnt_ff == $past(total_cnt_ff);
    endproperty
    a_busy_freeze: assert property (p_busy_freeze)
        else $error("fifo moved during retransmit recovery");

endmodule // dsf_fifo
`default_nettype wire

/* rtl/dsf_pkg.sv */
// constants, flag carrier and state type for the deep sync fifo
// assumes a single 125 MHz clock shared by writer, reader and fifo
package dsf_pkg;

    localparam int FIFO_WIDTH = 18;
    localparam int FIFO_DEPTH = 16384;
    localparam int STAGE_DEPTH = 8;
    localparam int CLK_NS = 8;
    localparam int RTR_NS = 60;
    localparam int RTR_CYC = (RTR_NS + CLK_NS - 1) / CLK_NS;
    localparam logic RST_FULL_N = 1'b1;
    localparam logic RST_EMPTY_N = 1'b0;
    localparam logic RST_AFULL_N = 1'b1;
    localparam logic RST_AEMPTY_N = 1'b0;
    localparam logic RST_BIT = 1'b0;

    // all active low, as on the pins
    typedef struct packed {
        logic full_indicator_n;
        logic empty_indicator_n;
        logic almost_full_indicator_n;
        logic almost_empty_indicator_n;
    } dsf_flags_s;

    typedef enum logic {
        RT_IDLE = 1'b0,
        RT_RECOV = 1'b1
    } dsf_rt_e;

endpackage
